// ===== common/ahbp_defines.svh
// constants of the asynchronous host bus port
`ifndef AHBP_DEFINES_SVH
`define AHBP_DEFINES_SVH

`define AHBP_DW          16
`define AHBP_AW          7
`define AHBP_CLK_NS      25
`define AHBP_DSU_NS      7
`define AHBP_DSU_CYC     ((`AHBP_DSU_NS + `AHBP_CLK_NS - 1) / `AHBP_CLK_NS)
`define AHBP_MAX_BURST   5'h10
`define AHBP_ONE_WORD    5'h01
`define AHBP_TXF_DEPTH   16
`define AHBP_DIRECT_MASK 7'h03
`define AHBP_RXD_LAST    7'h0F
`define AHBP_RXS_ADDR    7'h20
`define AHBP_RXS_PEEK    7'h21
`define AHBP_TXS_ADDR    7'h22
`define AHBP_TXS_PEEK    7'h23

`endif

// ===== common/ahbp_pkg.sv
// types of the asynchronous host bus port
package ahbp_pkg;

	typedef enum logic [1:0] {
		AHBP_IDLE  = 2'b00,
		AHBP_READ  = 2'b01,
		AHBP_WRITE = 2'b10
	} ahbp_state_t;

	typedef enum logic [1:0] {
		AHBP_SEL_CSR = 2'b00,
		AHBP_SEL_RXD = 2'b01,
		AHBP_SEL_RXS = 2'b10,
		AHBP_SEL_TXS = 2'b11
	} ahbp_rsel_t;

	typedef struct packed {
		logic        select_low;
		logic        read_strobe_low;
		logic        write_strobe_low;
		logic        fifo_sel;
		logic [6:0]  addr;
		logic [15:0] data;
	} ahbp_pins_t;

	typedef struct packed {
		logic       req;
		ahbp_rsel_t sel;
		logic [6:0] addr;
	} ahbp_rdreq_t;

	typedef struct packed {
		logic        req;
		logic [6:0]  addr;
		logic [15:0] data;
	} ahbp_wrreq_t;

	typedef struct packed {
		ahbp_pins_t  s1;
		ahbp_pins_t  s2;
		ahbp_state_t state;
		logic [6:0]  addr;
		logic        rd_fsel;
		logic [4:0]  nwords;
		logic        wfsel;
		logic [15:0] wdata;
		logic        tx_pend;
		logic        oe;
		logic [15:0] dout;
		ahbp_rdreq_t rd;
		ahbp_wrreq_t wr;
	} ahbp_port_state_t;

endpackage

// ===== src/ahbp_port.sv
// host bus port: strobe-framed reads and writes plus the transmit word FIFO
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_defines.svh"

module ahbp_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                full;
		logic                ne;
		logic [W-1:0]        head;
	} ahbp_fifo_state_t;

	ahbp_fifo_state_t f_q;
	ahbp_fifo_state_t f_d;
	logic             push;
	logic             pop;

	// flags and head word sit in flops so the transmit outputs leave registers
	assign in_ready  = !f_q.full;
	assign out_valid = f_q.ne;
	assign out_data  = f_q.head;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		f_d = f_q;
		if (push) begin
			f_d.mem[f_q.wp] = in_data;
			f_d.wp          = f_q.wp + 1'b1;
		end
		if (pop) begin
			f_d.rp = f_q.rp + 1'b1;
		end
		f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		f_d.full = (f_d.cnt == (AW+1)'(D));
		f_d.ne   = (f_d.cnt != '0);
		f_d.head = f_d.mem[f_d.rp];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

	default clocking fcb @(posedge clk); endclocking
	default disable iff (rst);

	hold_head_a: assert property ((out_valid && !out_ready) |=> out_valid && $stable(out_data))
		else $error("transmit head changed while stalled");
	keep_word_a: assert property ((in_valid && !in_ready) |=> in_valid && $stable(in_data))
		else $error("transmit word dropped while full");
endmodule // ahbp_fifo

module ahbp_port
	import ahbp_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        SELECT_LOW,
	input  wire logic        READ_STROBE_LOW,
	input  wire logic        WRITE_STROBE_LOW,
	input  wire logic        FIFO_SEL,
	input  wire logic [6:0]  ADDR,
	input  wire logic [15:0] DATA_I,
	output logic [15:0]      DATA_O,
	output logic             DATA_OE,
	output ahbp_rdreq_t      RD_REQ,
	input  wire logic [15:0] RD_DATA,
	output ahbp_wrreq_t      WR_REQ,
	output logic [15:0]      TX_DATA,
	output logic             TX_VALID,
	input  wire logic        TX_READY
);
	ahbp_port_state_t st_q;
	ahbp_port_state_t st_d;
	ahbp_pins_t       p;
	logic             rd_act;
	logic             wr_act;
	logic [6:0]       eff;
	logic             txf_ready;
	// synchroniser flops reset to idle pins so no false access follows reset
	localparam ahbp_pins_t pins_idle = '{select_low: 1'b1, read_strobe_low: 1'b1,
		write_strobe_low: 1'b1, default: '0};

	function automatic ahbp_rsel_t decode(input logic [6:0] a);
		if (a <= `AHBP_RXD_LAST) begin
			return AHBP_SEL_RXD;
		end else if (a == `AHBP_RXS_ADDR || a == `AHBP_RXS_PEEK) begin
			return AHBP_SEL_RXS;
		end else if (a == `AHBP_TXS_ADDR || a == `AHBP_TXS_PEEK) begin
			return AHBP_SEL_TXS;
		end
		return AHBP_SEL_CSR;
	endfunction

	assign p      = st_q.s2;
	assign rd_act = !p.select_low && !p.read_strobe_low;
	assign wr_act = !p.select_low && !p.write_strobe_low;
	// direct path keeps only the low address bits
	assign eff    = p.fifo_sel ? (p.addr & `AHBP_DIRECT_MASK) : p.addr;

	always_comb begin
		st_d        = st_q;
		st_d.s1     = {SELECT_LOW, READ_STROBE_LOW, WRITE_STROBE_LOW, FIFO_SEL, ADDR, DATA_I};
		st_d.s2     = st_q.s1;
		st_d.rd.req = 1'b0;
		st_d.wr.req = 1'b0;
		if (st_q.tx_pend && txf_ready) begin
			st_d.tx_pend = 1'b0;
		end
		case (st_q.state)
			AHBP_IDLE: begin
				if (rd_act) begin
					st_d.state   = AHBP_READ;
					st_d.oe      = 1'b1;
					st_d.addr    = eff;
					st_d.rd_fsel = p.fifo_sel;
					st_d.nwords  = `AHBP_ONE_WORD;
					st_d.rd.req  = 1'b1;
					st_d.rd.addr = eff;
					st_d.rd.sel  = p.fifo_sel ? AHBP_SEL_RXD : decode(eff);
				// a direct word still waiting for the FIFO holds off the next write
				end else if (wr_act && !st_q.tx_pend) begin
					st_d.state = AHBP_WRITE;
					st_d.addr  = eff;
					st_d.wfsel = p.fifo_sel;
					st_d.wdata = p.data;
				end
			end
			AHBP_READ: begin
				if (st_q.rd.req) begin
					st_d.dout = RD_DATA;
				end
				if (!rd_act) begin
					st_d.state = AHBP_IDLE;
					st_d.oe    = 1'b0;
				end else if ((st_q.rd_fsel ? (eff & `AHBP_DIRECT_MASK) : eff) != st_q.addr
						&& (st_q.rd_fsel || st_q.nwords < `AHBP_MAX_BURST)) begin
					// a new address inside the strobe is the next burst word, up to 16 words unless the burst is direct
					st_d.addr    = st_q.rd_fsel ? (eff & `AHBP_DIRECT_MASK) : eff;
					st_d.rd.req  = 1'b1;
					st_d.rd.addr = st_d.addr;
					st_d.rd.sel  = st_q.rd_fsel ? AHBP_SEL_RXD : decode(eff);
					if (st_q.nwords < `AHBP_MAX_BURST) begin
						st_d.nwords = st_q.nwords + 5'h01;
					end
				end
			end
			AHBP_WRITE: begin
				if (wr_act) begin
					// keep the last sample seen with the strobes low
					st_d.wdata = p.data;
				end else if (!st_q.tx_pend) begin
					st_d.state = AHBP_IDLE;
					if (st_q.wfsel) begin
						st_d.tx_pend = 1'b1;
					end else begin
						st_d.wr.req  = 1'b1;
						st_d.wr.addr = st_q.addr;
						st_d.wr.data = st_q.wdata;
					end
				end
			end
			default: begin
				st_d.state = AHBP_IDLE;
				st_d.oe    = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q    <= '0;
			st_q.s1 <= pins_idle;
			st_q.s2 <= pins_idle;
		end else begin
			st_q <= st_d;
		end
	end

	// transmit words wait here; a full FIFO keeps the word pending and holds off the next write in the idle state
	ahbp_fifo #(
		.W (`AHBP_DW),
		.D (`AHBP_TXF_DEPTH)
	) u_txf (
		.clk       (CLK),
		.rst       (RST),
		.in_valid  (st_q.tx_pend),
		.in_ready  (txf_ready),
		.in_data   (st_q.wdata),
		.out_valid (TX_VALID),
		.out_ready (TX_READY),
		.out_data  (TX_DATA)
	);

	assign DATA_O  = st_q.dout;
	assign DATA_OE = st_q.oe;
	assign RD_REQ  = st_q.rd;
	assign WR_REQ  = st_q.wr;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	rd_start_a: assert property ((st_q.state == AHBP_IDLE && rd_act) |=> RD_REQ.req && DATA_OE)
		else $error("read start not answered");
	wr_start_a: assert property ((st_q.state == AHBP_IDLE && wr_act && !rd_act && !st_q.tx_pend)
			|=> st_q.state == AHBP_WRITE)
		else $error("write start not taken");
	csr_snap_a: assert property ((RD_REQ.req && st_q.state == AHBP_READ && rd_act) |=> DATA_O == $past(RD_DATA))
		else $error("read word not taken after request");
	decode_a: assert property ((RD_REQ.req && !st_q.rd_fsel) |-> RD_REQ.sel == decode(RD_REQ.addr))
		else $error("read target mismatch");
	burst_cap_a: assert property (st_q.nwords <= `AHBP_MAX_BURST)
		else $error("burst word count above limit");
	fifo_dir_a: assert property ((RD_REQ.req && st_q.rd_fsel) |-> RD_REQ.sel == AHBP_SEL_RXD)
		else $error("direct read not from receive data");
	upper_ign_a: assert property ((RD_REQ.req && st_q.rd_fsel) |-> RD_REQ.addr[6:2] == 5'h00)
		else $error("upper address used in direct mode");
	unbound_a: assert property ((st_q.state == AHBP_READ && rd_act && st_q.rd_fsel
			&& (eff & `AHBP_DIRECT_MASK) != st_q.addr) |=> RD_REQ.req)
		else $error("direct burst word dropped");
	txpush_a: assert property ((st_q.state == AHBP_WRITE && !wr_act && st_q.wfsel && !st_q.tx_pend)
			|=> st_q.tx_pend && !WR_REQ.req)
		else $error("direct write not pushed");
	single_wr_a: assert property (WR_REQ.req |=> !WR_REQ.req ##1 !WR_REQ.req)
		else $error("write request longer than one word");
	wdata_a: assert property ((st_q.state == AHBP_WRITE && !wr_act && !st_q.wfsel && !st_q.tx_pend)
			|=> WR_REQ.req && WR_REQ.data == $past(p.data, 2))
		else $error("write data not the last sample before end");
	oe_a: assert property (DATA_OE == (st_q.state == AHBP_READ))
		else $error("data bus driven outside a read");
	rd_end_a: assert property ((st_q.state == AHBP_READ && !rd_act) |=> !DATA_OE && st_q.state == AHBP_IDLE)
		else $error("read end not seen");
	wr_end_a: assert property ((st_q.state == AHBP_WRITE && !wr_act && !st_q.tx_pend)
			|=> st_q.state == AHBP_IDLE)
		else $error("write end not seen");
	dout_hold_a: assert property (!RD_REQ.req |=> $stable(DATA_O))
		else $error("read word changed without a request");
	cap_stop_a: assert property ((st_q.state == AHBP_READ && !st_q.rd_fsel && st_q.nwords == `AHBP_MAX_BURST)
			|=> !RD_REQ.req)
		else $error("burst word taken beyond the limit");
	nw_start_a: assert property ((st_q.state == AHBP_IDLE && rd_act) |=> st_q.nwords == `AHBP_ONE_WORD)
		else $error("burst count not restarted");
	fsel_hold_a: assert property ((st_q.state == AHBP_READ) |=> $stable(st_q.rd_fsel))
		else $error("direct select changed inside a burst");
	rsel_take_a: assert property ((st_q.state == AHBP_IDLE && rd_act && p.fifo_sel)
			|=> st_q.rd_fsel && RD_REQ.sel == AHBP_SEL_RXD)
		else $error("direct select not taken at read start");
	wsel_take_a: assert property ((st_q.state == AHBP_IDLE && wr_act && !rd_act && !st_q.tx_pend
			&& p.fifo_sel) |=> st_q.wfsel)
		else $error("direct select not taken at write start");
	req_in_rd_a: assert property (RD_REQ.req |-> DATA_OE)
		else $error("read request outside a read");
	oe_rise_a: assert property ($rose(DATA_OE) |-> RD_REQ.req)
		else $error("bus driven without a read start");
	wr_quiet_a: assert property ((st_q.state == AHBP_WRITE) |-> !DATA_OE)
		else $error("data bus driven during a write");
	push_seen_a: assert property ((st_q.tx_pend && txf_ready) |=> TX_VALID)
		else $error("pushed word not offered");

	burst_c: cover property (st_q.state == AHBP_READ && RD_REQ.req ##[1:20] RD_REQ.req);
	direct_wr_c: cover property (st_q.tx_pend && txf_ready);
	full_c: cover property (st_q.tx_pend && !txf_ready);
	csr_wr_c: cover property (WR_REQ.req);
	dburst_c: cover property (st_q.rd_fsel && RD_REQ.req ##[1:20] RD_REQ.req);
endmodule // ahbp_port
`default_nettype wire

// ===== dv/ahbp_host_model.sv
// host bus master model that drives the port pins
`timescale 1ns/1ps
`default_nettype none
module ahbp_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] bus,
	output logic             select_low,
	output logic             read_strobe_low,
	output logic             write_strobe_low,
	output logic             fifo_sel,
	output logic [6:0]       addr,
	output logic [15:0]      data
);
	logic [15:0] got[$];
	initial begin
		select_low = 1'b1;
		read_strobe_low = 1'b1;
		write_strobe_low = 1'b1;
		fifo_sel = 1'b0;
		addr = 7'h00;
		data = 16'h0000;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// strobe leads select; each word's address is held for several cycles
	task automatic rd(input logic [6:0] a, input logic fs, input int words);
		fifo_sel = fs;
		read_strobe_low = 1'b0;
		cyc(1);
		select_low = 1'b0;
		for (int i = 0; i < words; i++) begin
			addr = a + 7'(i);
			cyc(6);
			@(posedge clk);
			#1 got.push_back(bus);
			cyc(1);
		end
		read_strobe_low = 1'b1;
		cyc(1);
		select_low = 1'b1;
		cyc(3);
	endtask
	// strobe ends the cycle first, select follows one cycle later
	task automatic wr(input logic [6:0] a, input logic fs, input logic [15:0] d);
		addr = a;
		fifo_sel = fs;
		data = d;
		select_low = 1'b0;
		write_strobe_low = 1'b0;
		cyc(4);
		write_strobe_low = 1'b1;
		cyc(1);
		select_low = 1'b1;
		data = ~d;
		cyc(13);
	endtask
endmodule // ahbp_host_model
`default_nettype wire

// ===== dv/ahbp_port_bench.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_defines.svh"
module ahbp_port_bench
	import ahbp_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        tx_ready = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic        sl, rl, wl, fs, data_oe, tx_valid;
	logic [6:0]  addr;
	logic [15:0] hdata, data_i, data_o, tx_data;
	ahbp_rdreq_t rd_req;
	ahbp_rdreq_t last_rd = '0;
	ahbp_wrreq_t wr_req;
	ahbp_wrreq_t last_wr = '0;
	int          rd_cnt = 0, wr_cnt = 0, num_errors = 0, compares = 0;

	always #12.5 clk = ~clk;
	assign data_i = data_oe ? data_o : hdata;

	ahbp_host_model u_host (
		.clk(clk), .bus(data_i), .select_low(sl), .read_strobe_low(rl), .write_strobe_low(wl),
		.fifo_sel(fs), .addr(addr), .data(hdata)
	);
	ahbp_port u_dut (
		.CLK(clk), .RST(rst), .SELECT_LOW(sl), .READ_STROBE_LOW(rl), .WRITE_STROBE_LOW(wl),
		.FIFO_SEL(fs), .ADDR(addr), .DATA_I(data_i), .DATA_O(data_o), .DATA_OE(data_oe),
		.RD_REQ(rd_req), .RD_DATA(rd_data), .WR_REQ(wr_req), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_READY(tx_ready)
	);

	function automatic logic [15:0] word_of(input ahbp_rsel_t s, input logic [6:0] a);
		return {7'h2C, s, a};
	endfunction
	// register side: answer each request inside its own cycle, scramble the word otherwise
	always @(posedge clk) begin
		if (rd_req.req === 1'b1) begin
			rd_cnt++;
			last_rd = rd_req;
		end
		if (wr_req.req === 1'b1) begin
			wr_cnt++;
			last_wr = wr_req;
		end
	end
	always @(negedge clk) rd_data <= (rd_req.req === 1'b1) ? word_of(rd_req.sel, rd_req.addr) : ~rd_data;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic t_reads();
		logic [6:0] a[4] = '{7'h32, 7'h03, 7'h20, 7'h22};
		ahbp_rsel_t s[4] = '{AHBP_SEL_CSR, AHBP_SEL_RXD, AHBP_SEL_RXS, AHBP_SEL_TXS};
		int n;
		for (int i = 0; i < 4; i++) begin
			n = rd_cnt;
			u_host.got.delete();
			u_host.rd(a[i], 1'b0, 1);
			check("read pulses", 32'(rd_cnt - n), 32'h1);
			check("read target", 32'(last_rd.sel), 32'(s[i]));
			check("read word", 32'(u_host.got[0]), 32'(word_of(s[i], a[i])));
			check("bus release", 32'(data_oe), 32'h0);
		end
		$display("reads done");
	endtask
	task automatic t_bursts();
		int n;
		n = rd_cnt;
		u_host.got.delete();
		u_host.rd(7'h40, 1'b0, 17);
		check("burst pulses", 32'(rd_cnt - n), 32'h10);
		check("burst word", 32'(u_host.got[15]), 32'(word_of(AHBP_SEL_CSR, 7'h4F)));
		n = rd_cnt;
		u_host.got.delete();
		u_host.rd(7'h7D, 1'b1, 18);
		check("direct pulses", 32'(rd_cnt - n), 32'h12);
		check("direct target", 32'(last_rd.sel), 32'(AHBP_SEL_RXD));
		check("direct word", 32'(u_host.got[0]), 32'(word_of(AHBP_SEL_RXD, 7'h7D & `AHBP_DIRECT_MASK)));
		$display("bursts done");
	endtask
	task automatic t_writes();
		int n;
		n = wr_cnt;
		u_host.wr(7'h31, 1'b0, 16'hBEEF);
		check("write pulses", 32'(wr_cnt - n), 32'h1);
		check("write addr", 32'(last_wr.addr), 32'h31);
		check("write data", 32'(last_wr.data), 32'hBEEF);
		// consumer stalls while sixteen direct words fill the buffer
		for (int i = 0; i < 16; i++)
			u_host.wr(7'(i), 1'b1, 16'hA000 + 16'(i));
		check("direct writes bypass", 32'(wr_cnt - n), 32'h1);
		tx_ready = 1'b1;
		n = 0;
		for (int j = 0; j < 60 && n < 16; j++) begin
			if (tx_valid === 1'b1) begin
				check("tx word", 32'(tx_data), 32'hA000 + 32'(n));
				n++;
			end
			@(negedge clk);
		end
		check("tx count", 32'(n), 32'h10);
		if (n != 16)
			wrap_up();
		check("tx empty", 32'(tx_valid), 32'h0);
		$display("writes done");
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		u_host.cyc(3);
		t_reads();
		t_bursts();
		t_writes();
		wrap_up();
	end
	initial begin
		#500000;
		num_errors++;
		wrap_up();
	end
endmodule // ahbp_port_bench
`default_nettype wire
